// [rtl/rcs_pkg.sv]
// constants for the reset and clock-ratio sequencer
// assumes mclk is the input clock, 100 MHz, and all pins are synchronous to it
package rcs_pkg;
  localparam int          CLK_PERIOD_NS     = 10;
  localparam logic [9:0]  STRETCH_CYCLES    = 10'h200;   // 512 input clocks
  localparam logic [9:0]  STRETCH_LAST      = STRETCH_CYCLES - 10'h001;
  localparam logic [2:0]  DIV_RESET         = 3'h7;      // divide by 8 (count 0..7)
  localparam logic [2:0]  DIV_SLOW          = 3'h7;      // divide by 8
  localparam logic [2:0]  DIV_CORE          = 3'h0;      // divide by 1
  localparam logic [2:0]  DIV_HALF          = 3'h1;      // divide by 2
  localparam int          CFG_BIT_HI        = 8;
  localparam int          CFG_BIT_MID       = 4;
  localparam int          CFG_BIT_LO        = 3;
  localparam logic [2:0]  CFG_RESET         = 3'h0;
  localparam int          NMI_MIN_PERIODS   = 2;
  localparam int          EXT_MIN_PERIODS   = 4;
  localparam logic        PLL_BYPASS_RESET  = 1'b1;
  typedef enum logic [1:0] {RCS_PIN_RESET, RCS_STRETCH, RCS_RUN} rcs_phase_type;
endpackage

// [rtl/rcs_sequencer.sv]
// reset sequencer with clock-ratio enables and pin-group reset control
// assumes reset_n_in is already synchronous to mclk; clocks are one-cycle enable pulses
// How it works
// RQ1: with input clock source, hold internal reset 512 clocks after reset release.
// RQ2: during reset pin and stretch, all internal clocks run at input clock over 8.
// RQ3: after reset, core clock runs at full input clock rate.
// RQ4: after reset, peripheral clock runs at input clock over 2.
// RQ5: after reset, memory clock at input over 2, shown on output when select is 0.
// RQ6: after reset, slow clock output runs at input clock over 8.
// RQ7: PLL stays bypassed right after reset; software changes it later.
// RQ8: capture host data bits 8 and 4:3 at reset rising edge.
// RQ9: memory bus pins and hold acknowledge float during reset.
// RQ10: bus request output driven low during reset.
// RQ11: serial port clocks, frame syncs, transmit data and timer outputs float in reset.
// RQ12: remaining host port and general I/O pins float in reset.
// RQ13: memory clock output and aux clock output float during reset.
// RQ14: slow clock output held low during reset.
// RQ15: interrupt source keeps NMI phases at least two CPU periods.
// RQ16: interrupt source keeps external interrupt phases at least four CPU periods.
// RQ17: stretch count starts on reset release and restarts if reset returns.
`timescale 1ns/100ps
module rcs_sequencer
  import rcs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        reset_n_in,
  input  wire logic        clock_source_select,
  input  wire logic        memory_clock_source_sel,
  input  wire logic [15:0] host_data_bus,
  output logic             internal_reset,
  output logic             cpu_core_clock,
  output logic             peripheral_clock,
  output logic             external_memory_clock,
  output logic             memory_clock_out,
  output logic             memory_clock_out_oe,
  output logic             aux_clock_out_b_oe,
  output logic             slow_clock_out,
  output logic             pll_bypass,
  output logic [2:0]       boot_config,
  output logic             memory_bus_oe,
  output logic             hold_acknowledge_oe,
  output logic             bus_request_force_low,
  output logic             serial_timer_oe,
  output logic             host_gpio_oe
);
  rcs_phase_type phase;
  logic [9:0]    stretch_count;
  logic          reset_n_prev;
  logic [2:0]    div_count;
  logic          in_reset;
  logic          release_edge;
  logic          pins_enable;

  assign release_edge = reset_n_in & ~reset_n_prev;
  assign in_reset     = (phase != RCS_RUN);
  assign pins_enable  = reset_n_in & ~rst;

  // tick when the free-running counter has every bit of the divide mask set
  function automatic logic tick(input logic [2:0] cnt, input logic [2:0] div);
    tick = ((cnt & div) == div);
  endfunction

  always_ff @(posedge mclk) begin
    if (rst) begin
      reset_n_prev <= 1'b0;
    end else begin
      reset_n_prev <= reset_n_in;
    end
  end

  // phase sequence; a reassertion at any point returns to pin reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase         <= RCS_PIN_RESET;
      stretch_count <= 10'h000;
    end else if (!reset_n_in) begin
      phase         <= RCS_PIN_RESET;               // see RQ17
      stretch_count <= 10'h000;
    end else begin
      unique case (phase)
        RCS_PIN_RESET: begin
          if (release_edge) begin
            stretch_count <= 10'h000;                // see RQ17
            // without the input clock source the stretch length is undefined; skip it
            phase <= clock_source_select ? RCS_STRETCH : RCS_RUN;
          end
        end
        RCS_STRETCH: begin
          if (stretch_count == STRETCH_LAST) begin
            phase <= RCS_RUN;                        // see RQ1
          end else begin
            stretch_count <= stretch_count + 10'h001;
          end
        end
        RCS_RUN: begin
          phase <= RCS_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      internal_reset <= 1'b1;
    end else begin
      internal_reset <= !reset_n_in || (phase != RCS_RUN) || release_edge;  // see RQ1
    end
  end

  // one shared divider; every rate is a one-cycle enable derived from it
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_count <= 3'h0;
    end else begin
      div_count <= div_count + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cpu_core_clock        <= 1'b0;
      peripheral_clock      <= 1'b0;
      external_memory_clock <= 1'b0;
    end else if (in_reset || !reset_n_in) begin
      cpu_core_clock        <= tick(div_count, DIV_RESET);   // see RQ2
      peripheral_clock      <= tick(div_count, DIV_RESET);   // see RQ2
      external_memory_clock <= tick(div_count, DIV_RESET);   // see RQ2
    end else begin
      cpu_core_clock        <= tick(div_count, DIV_CORE);    // see RQ3
      peripheral_clock      <= tick(div_count, DIV_HALF);    // see RQ4
      external_memory_clock <= tick(div_count, DIV_HALF);    // see RQ5
    end
  end

  // memory clock pin mirrors the run-rate memory clock only when sourced internally; it stays low in reset and stretch
  always_ff @(posedge mclk) begin
    if (rst) begin
      memory_clock_out <= 1'b0;
    end else if (!memory_clock_source_sel) begin
      memory_clock_out <= tick(div_count, DIV_HALF) && !in_reset && reset_n_in;  // see RQ5
    end else begin
      memory_clock_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      slow_clock_out <= 1'b0;
    end else if (!reset_n_in) begin
      slow_clock_out <= 1'b0;                                // see RQ14
    end else begin
      slow_clock_out <= tick(div_count, DIV_SLOW);           // see RQ6
    end
  end

  // pll controller is outside; this only presents the post-reset bypass state
  always_ff @(posedge mclk) begin
    if (rst) begin
      pll_bypass <= PLL_BYPASS_RESET;
    end else if (in_reset || !reset_n_in) begin
      pll_bypass <= PLL_BYPASS_RESET;                        // see RQ7
    end else begin
      pll_bypass <= pll_bypass;
    end
  end

  // straps are taken on the first clock that sees the reset pin high again
  always_ff @(posedge mclk) begin
    if (rst) begin
      boot_config <= CFG_RESET;
    end else if (reset_n_in && !reset_n_prev) begin
      boot_config <= {host_data_bus[CFG_BIT_HI], host_data_bus[CFG_BIT_MID],
                      host_data_bus[CFG_BIT_LO]};            // see RQ8
    end
  end

  // pin groups float (or force low) while the reset pin is low; one always block per group
  // so that a group-specific release delay can be added without touching the others
  always_ff @(posedge mclk) begin
    if (rst) begin
      memory_bus_oe       <= 1'b0;
      hold_acknowledge_oe <= 1'b0;
    end else begin
      memory_bus_oe       <= pins_enable;                    // see RQ9
      hold_acknowledge_oe <= pins_enable;                    // see RQ9
    end
  end

  // a floating bus request could read as a request at an external arbiter
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_request_force_low <= 1'b1;
    end else begin
      bus_request_force_low <= !pins_enable;                 // see RQ10
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      serial_timer_oe <= 1'b0;
    end else begin
      serial_timer_oe <= pins_enable;                        // see RQ11
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      host_gpio_oe <= 1'b0;
    end else begin
      host_gpio_oe <= pins_enable;                           // see RQ12
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      memory_clock_out_oe <= 1'b0;
      aux_clock_out_b_oe  <= 1'b0;
    end else begin
      memory_clock_out_oe <= pins_enable;                    // see RQ13
      aux_clock_out_b_oe  <= pins_enable;                    // see RQ13
    end
  end
endmodule

// [tb/rcs_board.sv]
// board side: reset source, boot straps on the host data bus and interrupt sources
// assumes the bench asks for reset through hold_in_reset, synchronous to mclk
`timescale 1ns/100ps
module rcs_board
  import rcs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        hold_in_reset,
  input  wire logic [2:0]  strap,
  input  wire logic        cpu_core_clock,
  output logic             reset_n_in,
  output logic [15:0]      host_data_bus,
  output logic             nonmaskable_interrupt_in,
  output logic             external_interrupt_in
);
  logic [3:0] hold_cnt;
  logic [1:0] irq_cnt;
  // every interrupt phase lasts a whole number of cpu clock pulses
  always_ff @(posedge mclk) begin
    if (hold_in_reset) begin
      irq_cnt                  <= 2'h0;
      nonmaskable_interrupt_in <= 1'b0;
      external_interrupt_in    <= 1'b0;
    end else if (cpu_core_clock) begin
      irq_cnt <= irq_cnt + 2'h1;
      if ((int'(irq_cnt) + 1) % NMI_MIN_PERIODS == 0) begin
        nonmaskable_interrupt_in <= !nonmaskable_interrupt_in;
      end
      if ((int'(irq_cnt) + 1) % EXT_MIN_PERIODS == 0) begin
        external_interrupt_in <= !external_interrupt_in;
      end
    end
  end
  always_ff @(posedge mclk) begin
    reset_n_in <= !hold_in_reset;
    hold_cnt   <= hold_in_reset ? 4'h0 : hold_cnt + {3'h0, !hold_cnt[3]};
  end
  // straps stay only a short hold after release, then the bus carries other traffic,
  // so a late capture in the sequencer reads the inverted pattern
  assign host_data_bus = hold_cnt[3] ? {7'h7f, ~strap[2], 3'h7, ~strap[1:0], 3'h7}
                                     : {7'h00, strap[2], 3'h0, strap[1:0], 3'h0};
endmodule

// [tb/rcs_sequencer_asserts.sv]
// timing checks on the sequencer ports, bound into rcs_sequencer
// assumes one clock mclk and the synchronous block reset rst
`timescale 1ns/100ps
module rcs_sequencer_asserts (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        reset_n_in,
  input wire logic        clock_source_select,
  input wire logic [15:0] host_data_bus,
  input wire logic        internal_reset,
  input wire logic        cpu_core_clock,
  input wire logic        peripheral_clock,
  input wire logic        slow_clock_out,
  input wire logic        pll_bypass,
  input wire logic        memory_bus_oe,
  input wire logic        hold_acknowledge_oe,
  input wire logic        serial_timer_oe,
  input wire logic        host_gpio_oe,
  input wire logic        memory_clock_out_oe,
  input wire logic        aux_clock_out_b_oe,
  input wire logic        bus_request_force_low,
  input wire logic [2:0]  boot_config
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_memory_bus_float: assert property (!reset_n_in |=>
    !memory_bus_oe && !hold_acknowledge_oe && !memory_clock_out_oe && !aux_clock_out_b_oe)
    else $error("bus driven in reset");
  a_bus_request_out_low: assert property (!reset_n_in |=> bus_request_force_low)
    else $error("bus request not low");
  a_ports_float: assert property (!reset_n_in |=> !serial_timer_oe && !host_gpio_oe)
    else $error("ports driven in reset");
  a_slow_held: assert property (!reset_n_in |=> !slow_clock_out)
    else $error("slow clock not low");
  a_core_divided: assert property (internal_reset && cpu_core_clock |=>
    !internal_reset || !cpu_core_clock) else $error("core clock fast in reset");
  a_core_full: assert property ((!internal_reset)[*2] |-> cpu_core_clock)
    else $error("core clock missing");
  a_periph_half: assert property ((!internal_reset)[*3] |->
    peripheral_clock != $past(peripheral_clock)) else $error("peripheral ratio");
  a_boot_capture: assert property ($rose(reset_n_in) |=> boot_config ==
    {$past(host_data_bus[8]), $past(host_data_bus[4:3])}) else $error("boot bits");
  a_pll_bypassed: assert property ($fell(internal_reset) |-> pll_bypass)
    else $error("pll not bypassed");
  a_stretch_exact: assert property ($fell(internal_reset) && clock_source_select |->
    $past(reset_n_in, 514) && !$past(reset_n_in, 515)) else $error("stretch length");
  c_release: cover property ($rose(reset_n_in));
  c_run: cover property ($fell(internal_reset));
  c_slow_pulse: cover property (internal_reset && cpu_core_clock);
  c_restart: cover property (internal_reset && reset_n_in ##1 !reset_n_in);
endmodule
bind rcs_sequencer rcs_sequencer_asserts i_chk (.mclk, .rst, .reset_n_in, .clock_source_select,
  .host_data_bus, .internal_reset, .cpu_core_clock, .peripheral_clock, .slow_clock_out,
  .pll_bypass, .memory_bus_oe, .hold_acknowledge_oe, .serial_timer_oe, .host_gpio_oe,
  .memory_clock_out_oe, .aux_clock_out_b_oe, .bus_request_force_low, .boot_config);

// [tb/rcs_sequencer_tb.sv]
// self-checking bench for the reset and clock-ratio sequencer
// assumes the board model drives the reset pin and straps one clock after a request
`timescale 1ns/100ps
module rcs_sequencer_tb;
  import rcs_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, hold_in_reset = 1'b1;
  logic clock_source_select = 1'b1, memory_clock_source_sel = 1'b0;
  logic [2:0] strap = 3'h5;
  logic [2:0] boot_config;
  logic [15:0] host_data_bus;
  logic reset_n_in, internal_reset, cpu_core_clock, peripheral_clock, external_memory_clock;
  logic memory_clock_out, memory_clock_out_oe, aux_clock_out_b_oe, slow_clock_out, pll_bypass;
  logic memory_bus_oe, hold_acknowledge_oe, bus_request_force_low, serial_timer_oe, host_gpio_oe;
  logic nonmaskable_interrupt_in, external_interrupt_in;
  logic [7:0] pins;
  int fail_count = 0, n_checks = 0, n, c[7];
  always #5 mclk = ~mclk;
  rcs_board i_board (.mclk, .hold_in_reset, .strap, .cpu_core_clock, .reset_n_in, .host_data_bus,
    .nonmaskable_interrupt_in, .external_interrupt_in);
  rcs_sequencer i_dut (.mclk, .rst, .reset_n_in, .clock_source_select, .memory_clock_source_sel,
    .host_data_bus, .internal_reset, .cpu_core_clock, .peripheral_clock, .external_memory_clock,
    .memory_clock_out, .memory_clock_out_oe, .aux_clock_out_b_oe, .slow_clock_out, .pll_bypass,
    .boot_config, .memory_bus_oe, .hold_acknowledge_oe, .bus_request_force_low,
    .serial_timer_oe, .host_gpio_oe);
  assign pins = {memory_bus_oe, hold_acknowledge_oe, serial_timer_oe, host_gpio_oe,
                 memory_clock_out_oe, aux_clock_out_b_oe, bus_request_force_low, internal_reset};
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // counts clock pulses and interrupt pin changes over a window
  task automatic run(input int cycles);
    logic nmi_q, ext_q;
    c = '{default: 0};
    nmi_q = nonmaskable_interrupt_in;
    ext_q = external_interrupt_in;
    repeat (cycles) begin
      @(posedge mclk);
      #1;
      c[0] += cpu_core_clock;
      c[1] += peripheral_clock;
      c[2] += memory_clock_out;
      c[3] += slow_clock_out;
      c[4] += external_memory_clock;
      c[5] += int'(nonmaskable_interrupt_in !== nmi_q);
      c[6] += int'(external_interrupt_in !== ext_q);
      nmi_q = nonmaskable_interrupt_in;
      ext_q = external_interrupt_in;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    run(2);
    rst = 1'b0;
    run(64);
    chk(16'(pins), 16'h0003);
    chk({8'(c[0]), 8'(c[1])}, 16'h0808);
    chk(16'(c[4]), 16'h0008);
    chk({8'(c[2]), 8'(c[3])}, 16'h0000);
    $display("pin reset test done");
    hold_in_reset = 1'b0;
    run(100);
    hold_in_reset = 1'b1;
    run(4);
    strap = 3'h2;
    hold_in_reset = 1'b0;
    n = 0;
    while (internal_reset !== 1'b0 && n < 2000) begin
      run(1);
      n++;
    end
    // one board register plus the sequencer's own latency around the stretch
    chk(16'(n), 16'(STRETCH_CYCLES) + 16'h3);
    if (n >= 2000) end_of_test();
    chk({boot_config, pll_bypass, bus_request_force_low}, {11'h0, 3'h2, 2'h2});
    $display("stretch test done");
    run(16);
    chk({8'(c[0]), 8'(c[1])}, 16'h1008);
    chk({8'(c[2]), 8'(c[3])}, 16'h0802);
    chk({8'(c[4]), 4'(c[5]), 4'(c[6])}, 16'h0884);
    chk(16'(pins), 16'h00fc);
    memory_clock_source_sel = 1'b1;
    run(2);
    run(16);
    chk(16'(c[2]), 16'h0);
    $display("run ratio test done");
    hold_in_reset = 1'b1;
    run(4);
    chk(16'(pins), 16'h0003);
    clock_source_select = 1'b0;
    memory_clock_source_sel = 1'b0;
    strap = 3'h4;
    hold_in_reset = 1'b0;
    n = 0;
    while (internal_reset !== 1'b0 && n < 2000) begin
      run(1);
      n++;
    end
    // same board and sequencer latency as the stretched release, with no stretch added
    chk(16'(n), 16'h0003);
    if (n >= 2000) end_of_test();
    run(8);
    chk({boot_config, 5'(c[0]), 8'(c[2])}, {3'h4, 5'h08, 8'h04});
    $display("restart without stretch test done");
    end_of_test();
  end
endmodule
